/* File: pcm_consts.svh */
// Named offsets, field positions, reset values and timing for the meter block
`ifndef PCM_CONSTS_SVH
`define PCM_CONSTS_SVH

// Register offsets
`define PCM_ADDR_METER 8'h1f
`define PCM_ADDR_CAP1 8'h20
`define PCM_ADDR_CAP2 8'h21

// Reset values
`define PCM_METER_RESET 8'h00
`define PCM_CAP_RESET 8'h00
`define PCM_ZERO8 8'h00

// Capability register field positions
`define PCM_BIT_HOLD 3'h7
`define PCM_BIT_FREQ 3'h5
`define PCM_BIT_EQ 3'h4
`define PCM_BIT_TWO_LANE 3'h3
`define PCM_BIT_LANE_SEL 3'h2

// Edge count ceiling
`define PCM_COUNT_MAX 8'hff
`define PCM_COUNT_ONE 8'h01

// Timing: system clock and oscillator period in ns
`define PCM_CLK_PERIOD_NS 8
`define PCM_OSC_PERIOD_NS 40
`define PCM_OSC_DIV_CYCLES \
	((`PCM_OSC_PERIOD_NS + `PCM_CLK_PERIOD_NS - 1) / `PCM_CLK_PERIOD_NS)

`endif

/* File: pcm_pkg.sv */
// Types shared by the pixel clock meter and sink capability block
package pcm_pkg;

	// Register access request from the register interface
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pcm_reg_req_t;

	// Capability word delivered by the back channel
	typedef struct packed {
		logic valid;
		logic freq_train;
		logic eq_train;
		logic two_lane;
		logic lane_sel;
	} pcm_bc_caps_t;

	// Meter sequencing
	typedef enum logic {
		pcm_idle,
		pcm_measure
	} pcm_meter_state_t;

	// Synchroniser state
	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
	} pcm_sync_state_t;

	// Divider state
	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} pcm_div_state_t;

	// Top level state
	typedef struct packed {
		pcm_meter_state_t meter;
		logic [7:0] edge_count;
		logic [7:0] remaining;
		logic hold;
		logic freq_req;
		logic eq_req;
		logic two_lane;
		logic lane_sel;
		logic [7:0] rdata;
		logic rvalid;
		logic busy;
	} pcm_top_state_t;

endpackage : pcm_pkg

/* File: pcm_sync.sv */
// Two flip-flop synchroniser with rising edge detect
`timescale 1ns/1ps

module pcm_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic async_in,
	output logic level,
	output logic rise
);

	pcm_pkg::pcm_sync_state_t q;
	pcm_pkg::pcm_sync_state_t next_q;

	// First stage feeds only the second stage
	always_comb begin
		next_q = q;
		next_q.s1 = async_in;
		next_q.s2 = q.s1;
		next_q.prev = q.s2;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// Edge seen only from the second stage onward
	assign level = q.s2;
	assign rise = q.s2 & ~q.prev;

endmodule : pcm_sync

/* File: pcm_osc_div.sv */
// Divider giving a one-cycle tick per oscillator period
`timescale 1ns/1ps

module pcm_osc_div #(
	parameter logic [7:0] DIV = 8'h05
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick
);

	pcm_pkg::pcm_div_state_t q;
	pcm_pkg::pcm_div_state_t next_q;

	// Count down, tick on wrap
	always_comb begin
		next_q = q;
		next_q.tick = 1'b0;
		if (q.cnt == 8'h00) begin
			next_q.cnt = DIV - 8'h01;
			next_q.tick = 1'b1;
		end else begin
			next_q.cnt = q.cnt - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign tick = q.tick;

endmodule : pcm_osc_div

/* File: pcm_top.sv */
// Pixel clock frequency meter and sink capability register bank
`timescale 1ns/1ps
`include "pcm_consts.svh"

module pcm_top #(
	parameter logic [7:0] OSC_DIV = 8'(`PCM_OSC_DIV_CYCLES)
) (
	input wire logic clk,
	input wire logic rst,
	input wire pcm_pkg::pcm_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic pix_clk,
	input wire logic rx_lock,
	input wire pcm_pkg::pcm_bc_caps_t bc_caps,
	output logic freq_training_request,
	output logic eq_training_request,
	output logic two_lane_capable,
	output logic lane_secondary,
	output logic capability_hold,
	output logic meter_busy
);

	pcm_pkg::pcm_top_state_t q;
	pcm_pkg::pcm_top_state_t next_q;

	logic pix_level;
	logic pix_rise;
	logic lock_level;
	logic osc_tick;
	logic wr_meter;
	logic wr_cap1;
	logic bc_load;
	logic [7:0] cap1_view;

	// Pixel clock pin into the system clock, edges detected after sync
	pcm_sync u_pix_sync (
		.clk(clk),
		.rst(rst),
		.async_in(pix_clk),
		.level(pix_level),
		.rise(pix_rise)
	);

	// Receiver lock arrives from outside this clock domain
	pcm_sync u_lock_sync (
		.clk(clk),
		.rst(rst),
		.async_in(rx_lock),
		.level(lock_level),
		.rise()
	);

	// Oscillator period as a tick enable
	pcm_osc_div #(
		.DIV(OSC_DIV)
	) u_osc_div (
		.clk(clk),
		.rst(rst),
		.tick(osc_tick)
	);

	// Write decode
	assign wr_meter = reg_req.wr && (reg_req.addr == `PCM_ADDR_METER);
	assign wr_cap1 = reg_req.wr && (reg_req.addr == `PCM_ADDR_CAP1);

	// Back channel load only when locked and not held
	assign bc_load = lock_level && bc_caps.valid && !q.hold;

	// Capability register as software sees it
	always_comb begin
		cap1_view = `PCM_CAP_RESET;
		cap1_view[`PCM_BIT_HOLD] = q.hold;
		cap1_view[`PCM_BIT_FREQ] = q.freq_req;
		cap1_view[`PCM_BIT_EQ] = q.eq_req;
		cap1_view[`PCM_BIT_TWO_LANE] = q.two_lane;
		cap1_view[`PCM_BIT_LANE_SEL] = q.lane_sel;
	end

	// Next state of the whole block
	always_comb begin
		next_q = q;
		next_q.rvalid = 1'b0;

		// Meter sequencing
		unique case (q.meter)
			pcm_pkg::pcm_idle: begin
				next_q.busy = 1'b0;
			end
			pcm_pkg::pcm_measure: begin
				// Count synchronised edges, stop at the ceiling
				if (pix_rise && (q.edge_count != `PCM_COUNT_MAX)) begin
					next_q.edge_count = q.edge_count + `PCM_COUNT_ONE;
				end
				// Interval counted in oscillator periods
				if (osc_tick) begin
					next_q.remaining = q.remaining - `PCM_COUNT_ONE;
					if (q.remaining == `PCM_COUNT_ONE) begin
						next_q.meter = pcm_pkg::pcm_idle;
						next_q.busy = 1'b0;
					end
				end
			end
		endcase

		// A write clears the count and restarts the meter; a zero write stops it instead
		if (wr_meter) begin
			next_q.edge_count = `PCM_METER_RESET;
			next_q.remaining = reg_req.wdata;
			if (reg_req.wdata != `PCM_ZERO8) begin
				next_q.meter = pcm_pkg::pcm_measure;
				next_q.busy = 1'b1;
			end else begin
				next_q.meter = pcm_pkg::pcm_idle;
				next_q.busy = 1'b0;
			end
		end

		// Automatic capability load from the back channel
		if (bc_load) begin
			next_q.freq_req = bc_caps.freq_train;
			next_q.eq_req = bc_caps.eq_train;
			next_q.two_lane = bc_caps.two_lane;
			next_q.lane_sel = bc_caps.lane_sel;
		end

		// Software write wins over a same-cycle back channel load
		if (wr_cap1) begin
			next_q.hold = reg_req.wdata[`PCM_BIT_HOLD];
			next_q.freq_req = reg_req.wdata[`PCM_BIT_FREQ];
			next_q.eq_req = reg_req.wdata[`PCM_BIT_EQ];
			next_q.two_lane = reg_req.wdata[`PCM_BIT_TWO_LANE];
			next_q.lane_sel = reg_req.wdata[`PCM_BIT_LANE_SEL];
		end

		// Read answer one cycle after the strobe
		if (reg_req.rd) begin
			next_q.rvalid = 1'b1;
			if (reg_req.addr == `PCM_ADDR_METER) begin
				next_q.rdata = q.edge_count;
			end else if (reg_req.addr == `PCM_ADDR_CAP1) begin
				next_q.rdata = cap1_view;
			end else begin
				next_q.rdata = `PCM_ZERO8;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			q.meter <= pcm_pkg::pcm_idle;
			q.edge_count <= `PCM_METER_RESET;
			q.remaining <= `PCM_ZERO8;
			q.hold <= 1'b0;
			q.freq_req <= 1'b0;
			q.eq_req <= 1'b0;
			q.two_lane <= 1'b0;
			q.lane_sel <= 1'b0;
			q.rdata <= `PCM_ZERO8;
			q.rvalid <= 1'b0;
			q.busy <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = q.rdata;
	assign reg_rvalid = q.rvalid;
	assign freq_training_request = q.freq_req;
	assign eq_training_request = q.eq_req;
	assign two_lane_capable = q.two_lane;
	assign lane_secondary = q.lane_sel;
	assign capability_hold = q.hold;
	assign meter_busy = q.busy;

endmodule : pcm_top

/* File: pcm_props.sv */
// Checker for the meter and capability register block
`timescale 1ns/1ps
module pcm_props #(
	parameter logic [7:0] OSC_DIV = 8'h05
) (
	input wire logic clk,
	input wire logic rst,
	input wire pcm_pkg::pcm_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic rx_lock,
	input wire pcm_pkg::pcm_bc_caps_t bc_caps,
	input wire logic freq_training_request,
	input wire logic eq_training_request,
	input wire logic two_lane_capable,
	input wire logic lane_secondary,
	input wire logic capability_hold,
	input wire logic meter_busy
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	logic [3:0] caps;
	logic mw;
	logic cw;
	// Capability word and decoded write strobes
	assign caps = {freq_training_request, eq_training_request,
		two_lane_capable, lane_secondary};
	assign mw = reg_req.wr && reg_req.addr == 8'h1f;
	assign cw = reg_req.wr && reg_req.addr == 8'h20;
	property p_rvalid;
		reg_req.rd |=> reg_rvalid;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("no rvalid");
	property p_start;
		mw && reg_req.wdata != 8'h00 |=> meter_busy;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_zero;
		mw && reg_req.wdata == 8'h00 |=> !meter_busy;
	endproperty
	a_zero: assert property (p_zero) else $error("zero ran");
	property p_short;
		mw && reg_req.wdata == 8'h01 |=> meter_busy ##[1:5] !meter_busy;
	endproperty
	a_short: assert property (p_short) else $error("bad span");
	property p_hold_wr;
		cw |=> {capability_hold, caps} ==
			$past({reg_req.wdata[7], reg_req.wdata[5:2]});
	endproperty
	a_hold_wr: assert property (p_hold_wr) else $error("cap write");
	property p_frozen;
		capability_hold && !cw |=> $stable({capability_hold, caps});
	endproperty
	a_frozen: assert property (p_frozen) else $error("cap moved");
	property p_rdcap;
		reg_req.rd && reg_req.addr == 8'h20 |=> reg_rdata ==
			{$past(capability_hold), 1'b0, $past(caps), 2'b00};
	endproperty
	a_rdcap: assert property (p_rdcap) else $error("cap read");
	property p_load;
		bc_caps.valid && !capability_hold && !cw && $past(rx_lock, 2) &&
			!$past(rst, 1) && !$past(rst, 2) |=>
			caps == $past(bc_caps[3:0]);
	endproperty
	a_load: assert property (p_load) else $error("no load");
endmodule : pcm_props
bind pcm_top pcm_props #(.OSC_DIV(OSC_DIV)) u_props (.clk, .rst, .reg_req,
	.reg_rdata, .reg_rvalid, .rx_lock, .bc_caps, .freq_training_request,
	.eq_training_request, .two_lane_capable, .lane_secondary,
	.capability_hold, .meter_busy);

/* File: pcm_sink_model.sv */
// Remote sink model: lock, back channel words and pixel clock
`timescale 1ns/1ps
module pcm_sink_model (
	input wire logic clk,
	input wire logic lock_en,
	input wire logic send,
	input wire logic [3:0] caps_word,
	input wire logic pix_run,
	input wire logic [7:0] pix_half_ns,
	output logic rx_lock = 1'b0,
	output pcm_pkg::pcm_bc_caps_t bc_caps = '0,
	output logic pix_clk = 1'b0
);
	// Pixel clock, parked low when stopped; odd start keeps edges off clk
	initial begin
		#1;
		forever #(pix_half_ns) pix_clk = pix_run ? ~pix_clk : 1'b0;
	end
	// Lock and one-cycle capability word; idle fields carry junk
	always @(posedge clk) begin
		rx_lock <= lock_en;
		bc_caps <= send ? {1'b1, caps_word} : {1'b0, ~caps_word};
	end
endmodule : pcm_sink_model

/* File: testbench.sv */
// Self-checking bench for the meter and capability register block
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	pcm_pkg::pcm_reg_req_t reg_req = '0;
	logic [7:0] reg_rdata;
	logic reg_rvalid, pix_clk, rx_lock, freq_training_request;
	logic eq_training_request, two_lane_capable, lane_secondary;
	logic capability_hold, meter_busy;
	pcm_pkg::pcm_bc_caps_t bc_caps;
	logic lock_en = 1'b0;
	logic send = 1'b0;
	logic pix_run = 1'b1;
	logic [3:0] caps_word = 4'h0;
	logic [7:0] pix_half = 8'h14;
	int failures = 0;
	int tests_run = 0;
	int n;
	// Clock at 125 MHz
	always #4 clk = ~clk;
	pcm_top dut (.clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .pix_clk,
		.rx_lock, .bc_caps, .freq_training_request, .eq_training_request,
		.two_lane_capable, .lane_secondary, .capability_hold, .meter_busy);
	pcm_sink_model u_far (.clk, .lock_en, .send, .caps_word, .pix_run,
		.pix_half_ns(pix_half), .rx_lock, .bc_caps, .pix_clk);
	task automatic wrap_up();
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string s, input logic [7:0] lo,
		input logic [7:0] hi, input logic [7:0] g);
		tests_run++;
		if (((g >= lo) && (g <= hi)) !== 1'b1) begin
			failures++;
			$display("MISMATCH %s exp %h..%h got %h", s, lo, hi, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		reg_req <= '0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] lo,
		input logic [7:0] hi);
		@(posedge clk);
		reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		reg_req <= '0;
		#1;
		chk("rvalid", 8'h01, 8'h01, {7'h0, reg_rvalid});
		chk("rdata", lo, hi, reg_rdata);
	endtask : rd
	task automatic ld(input logic [3:0] w);
		@(posedge clk);
		caps_word <= w;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : ld
	task automatic wb(input int lo, input int hi);
		n = 0;
		while (meter_busy === 1'b1 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		tests_run++;
		if (n < lo || n > hi) begin
			failures++;
			$display("MISMATCH busy_cycles exp %0d..%0d got %0d", lo, hi, n);
		end
		if (n >= 2000) wrap_up();
	endtask : wb
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(8'h1f, 8'h00, 8'h00);
		rd(8'h20, 8'h00, 8'h00);
		rd(8'h21, 8'h00, 8'h00);
		@(posedge clk) lock_en <= 1'b1;
		repeat (4) @(posedge clk);
		ld(4'b1010);
		rd(8'h20, 8'h28, 8'h28);
		ld(4'b0101);
		rd(8'h20, 8'h14, 8'h14);
		wr(8'h20, 8'ha0);
		ld(4'b0101);
		rd(8'h20, 8'ha0, 8'ha0);
		chk("pins", 8'h18, 8'h18, {3'h0, capability_hold,
			freq_training_request, eq_training_request,
			two_lane_capable, lane_secondary});
		wr(8'h21, 8'hff);
		wr(8'h20, 8'h00);
		ld(4'b1111);
		rd(8'h20, 8'h3c, 8'h3c);
		chk("pins", 8'h0f, 8'h0f, {3'h0, capability_hold,
			freq_training_request, eq_training_request,
			two_lane_capable, lane_secondary});
		wr(8'h1f, 8'h0a);
		chk("busy", 8'h01, 8'h01, {7'h0, meter_busy});
		wb(46, 50);
		rd(8'h1f, 8'h08, 8'h0b);
		pix_half = 8'h08;
		wr(8'h1f, 8'hff);
		wb(1271, 1275);
		rd(8'h1f, 8'hff, 8'hff);
		@(posedge clk) pix_run <= 1'b0;
		repeat (4) @(posedge clk);
		wr(8'h1f, 8'h01);
		wb(1, 5);
		rd(8'h1f, 8'h00, 8'h00);
		wr(8'h1f, 8'h00);
		chk("idle", 8'h00, 8'h00, {7'h0, meter_busy});
		wrap_up();
	end
endmodule : testbench
